// file: src/sci_bit_sampler.sv
/*
 Sixteen-fold bit sampler: votes on samples 8, 9 and 10 of each bit and reports noise
 when they disagree. Assumes a one-cycle sample tick and a bit start pulse that resyncs.
*/
`timescale 1ns/1ps
`default_nettype none
module sci_bit_sampler (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic sample_tick_in,
    input wire logic bit_start_in,
    input wire logic rx_in,
    output logic bit_done_out,
    output logic bit_value_out,
    output logic bit_noise_out
);
    typedef struct packed {
        sci_pkg::sampler_state_t state;
        logic [sci_pkg::SAMPLE_CNT_W-1:0] count;
        logic [2:0] votes;
        logic done;
        logic value;
        logic noise;
    } sampler_regs_t;

    sampler_regs_t s_reg;
    sampler_regs_t s_next;
    logic [sci_pkg::SAMPLE_CNT_W-1:0] idx;

    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        idx = s_reg.count + 5'h01;
        unique case (s_reg.state)
            sci_pkg::SAMP_IDLE: begin
            end
            sci_pkg::SAMP_RUN: begin
                if (sample_tick_in) begin
                    s_next.count = idx;
                    if (idx >= sci_pkg::VOTE_FIRST && idx <= sci_pkg::VOTE_LAST) begin
                        s_next.votes = {rx_in, s_reg.votes[2:1]};
                    end
                    if (idx == sci_pkg::SAMPLES_PER_BIT) begin
                        s_next.done = 1'b1;
                        s_next.value = (s_reg.votes[0] & s_reg.votes[1])
                            | (s_reg.votes[1] & s_reg.votes[2])
                            | (s_reg.votes[0] & s_reg.votes[2]);
                        s_next.noise = ~(&s_reg.votes) & (|s_reg.votes);
                        s_next.state = sci_pkg::SAMP_IDLE;
                    end
                end
            end
        endcase
        if (bit_start_in) begin
            s_next.state = sci_pkg::SAMP_RUN;
            s_next.count = '0;
        end
        if (srst_in) begin
            s_next.state = sci_pkg::SAMP_IDLE;
            s_next.count = '0;
            s_next.votes = 3'h0;
            s_next.done = 1'b0;
            s_next.value = 1'b1;
            s_next.noise = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        s_reg <= s_next;
    end

    assign bit_done_out = s_reg.done;
    assign bit_value_out = s_reg.value;
    assign bit_noise_out = s_reg.noise;

    a_noise_vote: assert property (@(posedge ref_clk_in) disable iff (srst_in)
        s_reg.done |-> (s_reg.noise == !($past(s_reg.votes) == 3'h0
            || $past(s_reg.votes) == 3'h7)))
        else $error("noise does not match disagreeing votes");
endmodule : sci_bit_sampler
`default_nettype wire

// file: src/sci_parity_check.sv
/*
 Receive parity checker: flags a word whose count of ones does not match the
 selected parity. Assumes the parity bit sits at the top of the 8 or 9 bit word.
*/
`timescale 1ns/1ps
`default_nettype none
module sci_parity_check (
    input wire logic [sci_pkg::WORD_W-1:0] word_in,
    input wire logic word_len_in,
    input wire logic odd_in,
    output logic error_out
);
    logic ones_odd;

    always_comb begin
        // short frames carry parity in bit 7, the ninth bit is not part of them
        if (word_len_in) begin
            ones_odd = ^word_in;
        end else begin
            ones_odd = ^word_in[sci_pkg::DATA_W-1:0];
        end
        error_out = ones_odd ^ odd_in;
    end
endmodule : sci_parity_check
`default_nettype wire

// file: src/sci_pkg.sv
/*
 Shared constants for the serial status flag block: register offsets, bit positions,
 reset values, frame kinds and the bit-sampler state type.
 Assumes a byte-wide register port with a three-bit address.
*/
package sci_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int WORD_W = 9;

    localparam logic [ADDR_W-1:0] OFS_STATUS = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_DATA = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_CTRL_A = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_CTRL_B = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_EVT_STATUS = 3'h4;
    localparam logic [ADDR_W-1:0] OFS_EVT_MASK = 3'h5;

    // status flag positions, also used by the event status and mask registers
    localparam int BIT_TX_EMPTY = 7;
    localparam int BIT_TX_DONE = 6;
    localparam int BIT_RX_FULL = 5;
    localparam int BIT_IDLE = 4;
    localparam int BIT_OVERRUN = 3;
    localparam int BIT_NOISE = 2;
    localparam int BIT_FRAMING = 1;
    localparam int BIT_PARITY = 0;

    // serial_control_reg_a fields
    localparam int BIT_WORD_LEN = 4;
    localparam int BIT_PARITY_EN = 2;
    localparam int BIT_PARITY_SEL = 1;
    localparam int BIT_PARITY_IRQ = 0;

    // serial_control_reg_b fields
    localparam int BIT_TX_EMPTY_IRQ = 7;
    localparam int BIT_COMPLETE_IRQ = 6;
    localparam int BIT_RECEIVE_IRQ = 5;
    localparam int BIT_IDLE_IRQ = 4;

    localparam logic [DATA_W-1:0] STATUS_RESET = 8'hC0;
    localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [DATA_W-1:0] EVT_RESET = 8'h00;
    localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

    localparam logic [1:0] KIND_DATA = 2'h0;
    localparam logic [1:0] KIND_PREAMBLE = 2'h1;
    localparam logic [1:0] KIND_BREAK = 2'h2;

    localparam int SAMPLE_CNT_W = 5;
    localparam logic [SAMPLE_CNT_W-1:0] SAMPLES_PER_BIT = 5'h10;
    localparam logic [SAMPLE_CNT_W-1:0] VOTE_FIRST = 5'h08;
    localparam logic [SAMPLE_CNT_W-1:0] VOTE_LAST = 5'h0A;

    typedef enum logic {SAMP_IDLE, SAMP_RUN} sampler_state_t;
endpackage : sci_pkg

// file: src/sci_status_flag_logic.sv
/*
 Status flag logic of an asynchronous serial interface: eight read-only flags, their
 clearing sequences, the shared serial interrupt and a maskable event register.
 Assumes the shift-register datapath, baud generator and idle detector sit outside and
 deliver one-cycle strobes synchronous to ref_clk_in.
*/
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - holding-to-shift move sets transmit-empty flag
// - transmit-empty with enable requests interrupt
// - status access then data write clears transmit flags
// - finished data frame sets complete flag, interrupt
// - preamble or break never sets complete flag
// - word into data register sets receive-ready
// - status access then data read clears receive flags
// - idle line sets idle flag, interrupt
// - idle rearms only after new received word
// - word ready while receive-ready set: overrun
// - overrun without framing error keeps old data in holding register
// - noise flag set, no own interrupt
// - framing error flag set, no own interrupt
// - framing plus overrun: transfer, overrun only
// - parity failure sets flag, optional interrupt
// - reset reads C0h, flags read-only
// - majority of samples 8-10, disagreement is noise
// - parity check even or odd count
module sci_status_flag_logic (
    input wire logic ref_clk_in,
    input wire logic srst_in,
    input wire logic [sci_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic [sci_pkg::DATA_W-1:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [sci_pkg::DATA_W-1:0] reg_rdata_out,
    input wire logic tx_load_in,
    input wire logic tx_frame_done_in,
    input wire logic [1:0] tx_frame_kind_in,
    input wire logic rx_word_ready_in,
    input wire logic [sci_pkg::WORD_W-1:0] rx_word_in,
    input wire logic rx_frame_err_in,
    input wire logic idle_detect_in,
    input wire logic rx_pin_in,
    input wire logic sample_tick_in,
    input wire logic bit_start_in,
    output logic sci_irq_out,
    output logic event_irq_out,
    output logic [sci_pkg::DATA_W-1:0] tx_data_out,
    output logic parity_en_out,
    output logic parity_select_out,
    output logic word_len_out
);
    typedef struct packed {
        logic [sci_pkg::DATA_W-1:0] status;
        logic [sci_pkg::DATA_W-1:0] rx_holding;
        logic [sci_pkg::DATA_W-1:0] tx_holding;
        logic [sci_pkg::DATA_W-1:0] ctrl_a;
        logic [sci_pkg::DATA_W-1:0] ctrl_b;
        logic [sci_pkg::DATA_W-1:0] evt_status;
        logic [sci_pkg::DATA_W-1:0] evt_mask;
        logic [sci_pkg::DATA_W-1:0] rdata;
        logic status_seen;
        logic idle_armed;
        logic noise_pend;
        logic sci_irq;
        logic evt_irq;
    } flag_regs_t;

    flag_regs_t r_reg;
    flag_regs_t r_next;

    logic bit_done;
    logic bit_value;
    logic bit_noise;
    logic parity_err;

    logic status_acc;
    logic data_rd;
    logic data_wr;
    logic overrun;
    logic xfer_word;
    logic clean_xfer;
    logic word_noise;
    logic [sci_pkg::DATA_W-1:0] set_vec;
    logic [sci_pkg::DATA_W-1:0] clr_vec;

    sci_bit_sampler u_sampler (
        .ref_clk_in(ref_clk_in),
        .srst_in(srst_in),
        .sample_tick_in(sample_tick_in),
        .bit_start_in(bit_start_in),
        .rx_in(rx_pin_in),
        .bit_done_out(bit_done),
        .bit_value_out(bit_value),
        .bit_noise_out(bit_noise)
    );

    sci_parity_check u_parity (
        .word_in(rx_word_in),
        .word_len_in(r_reg.ctrl_a[sci_pkg::BIT_WORD_LEN]),
        .odd_in(r_reg.ctrl_a[sci_pkg::BIT_PARITY_SEL]),
        .error_out(parity_err)
    );

    always_comb begin
        r_next = r_reg;
        status_acc = (reg_rd_in || reg_wr_in) && reg_addr_in == sci_pkg::OFS_STATUS;
        data_rd = reg_rd_in && reg_addr_in == sci_pkg::OFS_DATA;
        data_wr = reg_wr_in && reg_addr_in == sci_pkg::OFS_DATA;

        // a full holding register means the new word overruns it
        overrun = rx_word_ready_in && r_reg.status[sci_pkg::BIT_RX_FULL];
        // a framed-bad word that overruns still moves in, flagged as overrun only
        xfer_word = rx_word_ready_in
            && (!r_reg.status[sci_pkg::BIT_RX_FULL] || rx_frame_err_in);
        clean_xfer = xfer_word && !overrun;
        // the last bit's noise may land in the same cycle as the word strobe
        word_noise = r_reg.noise_pend || (bit_done && bit_noise);

        set_vec = '0;
        set_vec[sci_pkg::BIT_TX_EMPTY] = tx_load_in;
        set_vec[sci_pkg::BIT_TX_DONE] = tx_frame_done_in
            && tx_frame_kind_in == sci_pkg::KIND_DATA;
        set_vec[sci_pkg::BIT_RX_FULL] = xfer_word;
        set_vec[sci_pkg::BIT_IDLE] = idle_detect_in && r_reg.idle_armed;
        set_vec[sci_pkg::BIT_OVERRUN] = overrun;
        set_vec[sci_pkg::BIT_NOISE] = clean_xfer && word_noise;
        set_vec[sci_pkg::BIT_FRAMING] = clean_xfer && rx_frame_err_in;
        set_vec[sci_pkg::BIT_PARITY] = clean_xfer
            && r_reg.ctrl_a[sci_pkg::BIT_PARITY_EN] && parity_err;

        clr_vec = '0;
        if (r_reg.status_seen && data_wr) begin
            clr_vec[sci_pkg::BIT_TX_EMPTY] = 1'b1;
            clr_vec[sci_pkg::BIT_TX_DONE] = 1'b1;
        end
        if (r_reg.status_seen && data_rd) begin
            clr_vec[sci_pkg::BIT_RX_FULL] = 1'b1;
            clr_vec[sci_pkg::BIT_IDLE] = 1'b1;
            clr_vec[sci_pkg::BIT_OVERRUN] = 1'b1;
            clr_vec[sci_pkg::BIT_NOISE] = 1'b1;
            clr_vec[sci_pkg::BIT_FRAMING] = 1'b1;
        end
        // parity clears on either kind of data access after the status access
        if (r_reg.status_seen && (data_rd || data_wr)) begin
            clr_vec[sci_pkg::BIT_PARITY] = 1'b1;
        end
        // set beats clear so an event landing on the clearing access survives
        r_next.status = (r_reg.status & ~clr_vec) | set_vec;

        if (status_acc) begin
            r_next.status_seen = 1'b1;
        end else if (data_rd || data_wr) begin
            r_next.status_seen = 1'b0;
        end

        if (set_vec[sci_pkg::BIT_RX_FULL]) begin
            r_next.idle_armed = 1'b1;
        end else if (set_vec[sci_pkg::BIT_IDLE]) begin
            r_next.idle_armed = 1'b0;
        end

        if (rx_word_ready_in) begin
            r_next.noise_pend = 1'b0;
        end else if (bit_done && bit_noise) begin
            r_next.noise_pend = 1'b1;
        end

        if (xfer_word) begin
            r_next.rx_holding = rx_word_in[sci_pkg::DATA_W-1:0];
        end

        r_next.rdata = sci_pkg::READ_ZERO;
        if (reg_rd_in) begin
            unique case (reg_addr_in)
                sci_pkg::OFS_STATUS: r_next.rdata = r_reg.status;
                sci_pkg::OFS_DATA: r_next.rdata = r_reg.rx_holding;
                sci_pkg::OFS_CTRL_A: r_next.rdata = r_reg.ctrl_a;
                sci_pkg::OFS_CTRL_B: r_next.rdata = r_reg.ctrl_b;
                sci_pkg::OFS_EVT_STATUS: r_next.rdata = r_reg.evt_status;
                sci_pkg::OFS_EVT_MASK: r_next.rdata = r_reg.evt_mask;
                default: r_next.rdata = sci_pkg::READ_ZERO;
            endcase
        end

        // status itself ignores writes: the flags are read-only
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                sci_pkg::OFS_DATA: r_next.tx_holding = reg_wdata_in;
                sci_pkg::OFS_CTRL_A: r_next.ctrl_a = reg_wdata_in;
                sci_pkg::OFS_CTRL_B: r_next.ctrl_b = reg_wdata_in;
                sci_pkg::OFS_EVT_MASK: r_next.evt_mask = reg_wdata_in;
                default: begin
                end
            endcase
        end

        if (reg_wr_in && reg_addr_in == sci_pkg::OFS_EVT_STATUS) begin
            r_next.evt_status = (r_reg.evt_status & ~reg_wdata_in) | set_vec;
        end else begin
            r_next.evt_status = r_reg.evt_status | set_vec;
        end
        r_next.evt_irq = |(r_next.evt_status & r_next.evt_mask);

        // noise and framing have no enable: they ride on receive-ready
        r_next.sci_irq = (r_next.status[sci_pkg::BIT_TX_EMPTY]
                & r_next.ctrl_b[sci_pkg::BIT_TX_EMPTY_IRQ])
            | (r_next.status[sci_pkg::BIT_TX_DONE]
                & r_next.ctrl_b[sci_pkg::BIT_COMPLETE_IRQ])
            | (r_next.status[sci_pkg::BIT_RX_FULL]
                & r_next.ctrl_b[sci_pkg::BIT_RECEIVE_IRQ])
            | (r_next.status[sci_pkg::BIT_OVERRUN]
                & r_next.ctrl_b[sci_pkg::BIT_RECEIVE_IRQ])
            | (r_next.status[sci_pkg::BIT_IDLE]
                & r_next.ctrl_b[sci_pkg::BIT_IDLE_IRQ])
            | (r_next.status[sci_pkg::BIT_PARITY]
                & r_next.ctrl_a[sci_pkg::BIT_PARITY_IRQ]);

        if (srst_in) begin
            r_next.status = sci_pkg::STATUS_RESET;
            r_next.rx_holding = sci_pkg::CTRL_RESET;
            r_next.tx_holding = sci_pkg::CTRL_RESET;
            r_next.ctrl_a = sci_pkg::CTRL_RESET;
            r_next.ctrl_b = sci_pkg::CTRL_RESET;
            r_next.evt_status = sci_pkg::EVT_RESET;
            r_next.evt_mask = sci_pkg::EVT_RESET;
            r_next.rdata = sci_pkg::READ_ZERO;
            r_next.status_seen = 1'b0;
            r_next.idle_armed = 1'b1;
            r_next.noise_pend = 1'b0;
            r_next.sci_irq = 1'b0;
            r_next.evt_irq = 1'b0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        r_reg <= r_next;
    end

    assign reg_rdata_out = r_reg.rdata;
    assign sci_irq_out = r_reg.sci_irq;
    assign event_irq_out = r_reg.evt_irq;
    assign tx_data_out = r_reg.tx_holding;
    assign parity_en_out = r_reg.ctrl_a[sci_pkg::BIT_PARITY_EN];
    assign parity_select_out = r_reg.ctrl_a[sci_pkg::BIT_PARITY_SEL];
    assign word_len_out = r_reg.ctrl_a[sci_pkg::BIT_WORD_LEN];

    default clocking cb @(posedge ref_clk_in);
    endclocking
    default disable iff (srst_in);

    a_tx_empty_set: assert property (tx_load_in |=> r_reg.status[7])
        else $error("transmit-empty not set after load");

    a_tx_empty_irq: assert property (
        (r_reg.status[7] && r_reg.ctrl_b[7]) |-> sci_irq_out)
        else $error("transmit-empty interrupt missing");

    a_tx_clear_seq: assert property (
        (reg_rd_in && reg_addr_in == 3'h0) ##1 !(reg_rd_in || reg_wr_in) ##1
        (reg_wr_in && reg_addr_in == 3'h1 && !tx_load_in && !tx_frame_done_in)
        |=> !r_reg.status[7] && !r_reg.status[6])
        else $error("transmit flags not cleared by sequence");

    a_done_data_only: assert property (
        (tx_frame_done_in && tx_frame_kind_in != 2'h0 && !r_reg.status[6])
        |=> !r_reg.status[6])
        else $error("complete flag set by preamble or break");

    a_rx_word_xfer: assert property (
        (rx_word_ready_in && !r_reg.status[5]) |=>
        (r_reg.status[5] && r_reg.rx_holding == $past(rx_word_in[7:0])))
        else $error("received word not transferred");

    a_rx_clear_seq: assert property (
        (reg_rd_in && reg_addr_in == 3'h0) ##1 !(reg_rd_in || reg_wr_in) ##1
        (reg_rd_in && reg_addr_in == 3'h1 && !rx_word_ready_in && !idle_detect_in)
        |=> (r_reg.status[5:1] == 5'h00))
        else $error("receive flags not cleared by sequence");

    a_idle_no_rearm: assert property (
        (!r_reg.idle_armed && !rx_word_ready_in) |=> !$rose(r_reg.status[4]))
        else $error("idle flag set again without new word");

    a_overrun_keep: assert property (
        (rx_word_ready_in && r_reg.status[5] && !rx_frame_err_in)
        |=> (r_reg.status[3] && $stable(r_reg.rx_holding)))
        else $error("overrun lost or holding data overwritten");

    a_frame_overrun: assert property (
        (rx_word_ready_in && r_reg.status[5] && rx_frame_err_in && !r_reg.status[1])
        |=> (r_reg.status[3] && !r_reg.status[1]
            && r_reg.rx_holding == $past(rx_word_in[7:0])))
        else $error("framing with overrun handled wrongly");

    a_status_reset: assert property (
        @(posedge ref_clk_in) disable iff (1'b0)
        srst_in |=> (r_reg.status == 8'hC0 && !sci_irq_out))
        else $error("status reset value wrong");
endmodule : sci_status_flag_logic
`default_nettype wire

// file: verification/remote_node_model.sv
/*
 Far-side serial node model: drives the transmit and receive event strobes and the sampled line.
 Assumes the bench calls its tasks from one process; every change lands just after a rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
module remote_node_model (
    input wire logic ref_clk_in,
    output logic tx_load_out,
    output logic tx_frame_done_out,
    output logic [1:0] tx_frame_kind_out,
    output logic rx_word_ready_out,
    output logic [sci_pkg::WORD_W-1:0] rx_word_out,
    output logic rx_frame_err_out,
    output logic idle_detect_out,
    output logic rx_pin_out,
    output logic sample_tick_out,
    output logic bit_start_out
);
    initial begin
        tx_load_out = 1'b0;
        tx_frame_done_out = 1'b0;
        tx_frame_kind_out = 2'h3;
        rx_word_ready_out = 1'b0;
        rx_word_out = 9'h1FF;
        rx_frame_err_out = 1'b1;
        idle_detect_out = 1'b0;
        rx_pin_out = 1'b1;
        sample_tick_out = 1'b0;
        bit_start_out = 1'b0;
    end
    task automatic load();
        @(posedge ref_clk_in) tx_load_out <= 1'b1;
        @(posedge ref_clk_in) tx_load_out <= 1'b0;
    endtask : load
    // qualifiers go to their inverse once released, so a stale value is never trusted
    task automatic frame(input logic [1:0] kind);
        @(posedge ref_clk_in) tx_frame_kind_out <= kind;
        tx_frame_done_out <= 1'b1;
        @(posedge ref_clk_in) tx_frame_done_out <= 1'b0;
        tx_frame_kind_out <= ~kind;
    endtask : frame
    task automatic word(input logic [8:0] w, input logic fe, input int gap);
        repeat (gap) @(posedge ref_clk_in);
        @(posedge ref_clk_in) rx_word_out <= w;
        rx_frame_err_out <= fe;
        rx_word_ready_out <= 1'b1;
        @(posedge ref_clk_in) rx_word_ready_out <= 1'b0;
        rx_word_out <= ~w;
        rx_frame_err_out <= ~fe;
    endtask : word
    task automatic idle();
        @(posedge ref_clk_in) idle_detect_out <= 1'b1;
        @(posedge ref_clk_in) idle_detect_out <= 1'b0;
    endtask : idle
    // one bit window, sample k taken from s[k-1]; line idles high afterwards
    task automatic bit_samples(input logic [15:0] s);
        @(posedge ref_clk_in) bit_start_out <= 1'b1;
        @(posedge ref_clk_in) bit_start_out <= 1'b0;
        for (int i = 0; i < 16; i++) begin
            @(posedge ref_clk_in) rx_pin_out <= s[i];
            sample_tick_out <= 1'b1;
            @(posedge ref_clk_in) sample_tick_out <= 1'b0;
        end
        @(posedge ref_clk_in) rx_pin_out <= 1'b1;
    endtask : bit_samples
endmodule : remote_node_model
`default_nettype wire

// file: verification/sci_status_flag_logic_tb.sv
/*
 Self-checking bench for the serial status flag block.
 Assumes the remote node model drives the event side and this module the register port.
*/
`timescale 1ns/1ps
`default_nettype none
module sci_status_flag_logic_tb;
    logic ref_clk_in, srst_in, reg_wr_in, reg_rd_in;
    logic [2:0] reg_addr_in;
    logic [7:0] reg_wdata_in, reg_rdata_out, tx_data_out;
    logic sci_irq_out, event_irq_out, parity_en_out, parity_select_out, word_len_out;
    logic tx_load, tx_done, rdy, fe, idl, pin, tick, bstart;
    logic [1:0] kind;
    logic [8:0] rword;
    int err_total = 0;
    int check_count = 0;

    sci_status_flag_logic dut (.ref_clk_in(ref_clk_in), .srst_in(srst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out), .tx_load_in(tx_load),
        .tx_frame_done_in(tx_done), .tx_frame_kind_in(kind), .rx_word_ready_in(rdy),
        .rx_word_in(rword), .rx_frame_err_in(fe), .idle_detect_in(idl), .rx_pin_in(pin),
        .sample_tick_in(tick), .bit_start_in(bstart), .sci_irq_out(sci_irq_out),
        .event_irq_out(event_irq_out), .tx_data_out(tx_data_out),
        .parity_en_out(parity_en_out), .parity_select_out(parity_select_out),
        .word_len_out(word_len_out));
    remote_node_model node (.ref_clk_in(ref_clk_in), .tx_load_out(tx_load),
        .tx_frame_done_out(tx_done), .tx_frame_kind_out(kind), .rx_word_ready_out(rdy),
        .rx_word_out(rword), .rx_frame_err_out(fe), .idle_detect_out(idl), .rx_pin_out(pin),
        .sample_tick_out(tick), .bit_start_out(bstart));

    initial begin
        ref_clk_in = 1'b0;
        forever #2 ref_clk_in = ~ref_clk_in;
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : chk
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk_in) reg_addr_in <= a;
        reg_wdata_in <= v;
        reg_wr_in <= 1'b1;
        @(posedge ref_clk_in) reg_wr_in <= 1'b0;
    endtask : wr
    // read data stands only in the cycle after the strobe
    task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
        @(posedge ref_clk_in) reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge ref_clk_in) reg_rd_in <= 1'b0;
        @(negedge ref_clk_in) chk(reg_rdata_out, exp);
    endtask : rchk
    task automatic irqchk(input logic s, input logic e);
        @(negedge ref_clk_in) chk({6'h00, event_irq_out, sci_irq_out}, {6'h00, e, s});
    endtask : irqchk

    task automatic t_reset();
        rchk(sci_pkg::OFS_STATUS, 8'hC0);
        wr(sci_pkg::OFS_STATUS, 8'h00);
        wr(3'h7, 8'hFF);
        rchk(sci_pkg::OFS_STATUS, 8'hC0);
        rchk(3'h6, 8'h00);
        irqchk(1'b0, 1'b0);
    endtask : t_reset
    task automatic t_tx();
        wr(sci_pkg::OFS_CTRL_B, 8'hC0);
        irqchk(1'b1, 1'b0);
        rchk(sci_pkg::OFS_STATUS, 8'hC0);
        wr(sci_pkg::OFS_DATA, 8'h5A);
        rchk(sci_pkg::OFS_STATUS, 8'h00);
        chk(tx_data_out, 8'h5A);
        irqchk(1'b0, 1'b0);
        node.frame(sci_pkg::KIND_PREAMBLE);
        node.frame(sci_pkg::KIND_BREAK);
        rchk(sci_pkg::OFS_STATUS, 8'h00);
        node.load();
        rchk(sci_pkg::OFS_STATUS, 8'h80);
        irqchk(1'b1, 1'b0);
        node.frame(sci_pkg::KIND_DATA);
        wr(sci_pkg::OFS_CTRL_B, 8'h40);
        rchk(sci_pkg::OFS_STATUS, 8'hC0);
        irqchk(1'b1, 1'b0);
        wr(sci_pkg::OFS_DATA, 8'hA5);
        rchk(sci_pkg::OFS_STATUS, 8'h00);
        irqchk(1'b0, 1'b0);
    endtask : t_tx
    task automatic t_rx();
        wr(sci_pkg::OFS_CTRL_B, 8'h20);
        node.word(9'h041, 1'b0, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h20);
        irqchk(1'b1, 1'b0);
        node.word(9'h0A5, 1'b0, 3);
        rchk(sci_pkg::OFS_STATUS, 8'h28);
        rchk(sci_pkg::OFS_DATA, 8'h41);
        rchk(sci_pkg::OFS_STATUS, 8'h00);
        irqchk(1'b0, 1'b0);
        node.word(9'h011, 1'b0, 0);
        node.word(9'h022, 1'b1, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h28);
        rchk(sci_pkg::OFS_DATA, 8'h22);
        wr(sci_pkg::OFS_CTRL_B, 8'h00);
    endtask : t_rx
    task automatic t_err();
        node.word(9'h033, 1'b1, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h22);
        irqchk(1'b0, 1'b0);
        rchk(sci_pkg::OFS_DATA, 8'h33);
        node.bit_samples(16'hFEFF);
        node.word(9'h044, 1'b0, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h24);
        irqchk(1'b0, 1'b0);
        rchk(sci_pkg::OFS_DATA, 8'h44);
        node.bit_samples(16'hFC7F);
        node.word(9'h045, 1'b0, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h20);
        rchk(sci_pkg::OFS_DATA, 8'h45);
        wr(sci_pkg::OFS_CTRL_A, 8'h05);
        node.word(9'h001, 1'b0, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h21);
        irqchk(1'b1, 1'b0);
        rchk(sci_pkg::OFS_DATA, 8'h01);
        node.word(9'h003, 1'b0, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h20);
        rchk(sci_pkg::OFS_DATA, 8'h03);
        wr(sci_pkg::OFS_CTRL_A, 8'h17);
        // the copies update on the write's edge, so look half a cycle later
        @(negedge ref_clk_in) chk({5'h00, word_len_out, parity_en_out, parity_select_out}, 8'h07);
        node.word(9'h101, 1'b0, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h21);
        wr(sci_pkg::OFS_DATA, 8'h00);
        rchk(sci_pkg::OFS_STATUS, 8'h20);
        rchk(sci_pkg::OFS_DATA, 8'h01);
        node.word(9'h100, 1'b0, 0);
        rchk(sci_pkg::OFS_STATUS, 8'h20);
        rchk(sci_pkg::OFS_DATA, 8'h00);
        wr(sci_pkg::OFS_CTRL_A, 8'h00);
    endtask : t_err
    task automatic t_idle();
        wr(sci_pkg::OFS_CTRL_B, 8'h10);
        node.idle();
        rchk(sci_pkg::OFS_STATUS, 8'h10);
        irqchk(1'b1, 1'b0);
        rchk(sci_pkg::OFS_DATA, 8'h00);
        node.idle();
        rchk(sci_pkg::OFS_STATUS, 8'h00);
        irqchk(1'b0, 1'b0);
        node.word(9'h055, 1'b0, 0);
        node.idle();
        rchk(sci_pkg::OFS_STATUS, 8'h30);
        rchk(sci_pkg::OFS_DATA, 8'h55);
        wr(sci_pkg::OFS_CTRL_B, 8'h00);
    endtask : t_idle
    task automatic t_event();
        wr(sci_pkg::OFS_EVT_STATUS, 8'hFF);
        rchk(sci_pkg::OFS_EVT_STATUS, 8'h00);
        wr(sci_pkg::OFS_EVT_MASK, 8'h20);
        rchk(sci_pkg::OFS_EVT_MASK, 8'h20);
        node.word(9'h066, 1'b0, 0);
        rchk(sci_pkg::OFS_EVT_STATUS, 8'h20);
        irqchk(1'b0, 1'b1);
        wr(sci_pkg::OFS_EVT_MASK, 8'h00);
        irqchk(1'b0, 1'b0);
        wr(sci_pkg::OFS_EVT_MASK, 8'h20);
        wr(sci_pkg::OFS_EVT_STATUS, 8'h20);
        rchk(sci_pkg::OFS_EVT_STATUS, 8'h00);
        irqchk(1'b0, 1'b0);
    endtask : t_event

    task automatic wrap_up();
        $display("checks=%0d errors=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : wrap_up
    // the whole sequence needs well under a thousand cycles; 10000 is a wide margin
    initial begin
        #40000;
        err_total++;
        wrap_up();
    end
    initial begin
        srst_in = 1'b1;
        reg_addr_in = 3'h0;
        reg_wdata_in = 8'h00;
        reg_wr_in = 1'b0;
        reg_rd_in = 1'b0;
        repeat (6) @(posedge ref_clk_in);
        srst_in <= 1'b0;
        t_reset();
        t_tx();
        t_rx();
        t_err();
        t_idle();
        t_event();
        wrap_up();
    end
endmodule : sci_status_flag_logic_tb
`default_nettype wire
